//--- qli_pkg.sv
// Constants and types shared by the quad-port indicator block.
package qli_pkg;

    // ------------------------------------------------------------------
    // Geometry of ports and the serial frame
    // ------------------------------------------------------------------
    localparam int NUM_PORTS = 4;
    localparam int BITS_PER_PORT = 6;
    localparam int FRAME_BITS = NUM_PORTS * BITS_PER_PORT;
    localparam int GAP_BITS = 8;
    localparam logic [4:0] FRAME_LAST = 5'h17;
    localparam logic [4:0] GAP_LAST = 5'h07;

    // ------------------------------------------------------------------
    // Clock rates; the link clock is divided to make the shift clock
    // ------------------------------------------------------------------
    localparam int SYS_CLK_MHZ = 50;
    localparam int SHIFT_CLK_MHZ = 25;
    localparam int LINK_CLK_MHZ = 50;
    localparam int LINK_CYCLES_PER_HALF = LINK_CLK_MHZ / (2 * SHIFT_CLK_MHZ);

    // ------------------------------------------------------------------
    // Status condition positions inside one port's six-bit group
    // ------------------------------------------------------------------
    localparam int ST_TX = 0;
    localparam int ST_RX = 1;
    localparam int ST_LINK = 2;
    localparam int ST_DUPLEX = 3;
    localparam int ST_SPEED = 4;
    localparam int ST_COL = 5;

    // ------------------------------------------------------------------
    // Register indices; byte address is four times the index
    // ------------------------------------------------------------------
    localparam logic [5:0] REG_IDX_SCRATCH_HI = 6'h06;
    localparam logic [5:0] REG_IDX_LEDCFG_LO = 6'h10;
    localparam logic [5:0] REG_IDX_LEDCFG_HI = 6'h13;
    localparam logic [5:0] REG_IDX_PINS = 6'h14;
    localparam int REG_BITS = 16;

    // ------------------------------------------------------------------
    // Indicator configuration field layout and selector codes
    // ------------------------------------------------------------------
    localparam int CFG_A_LSB = 0;
    localparam int CFG_B_LSB = 2;
    localparam int CFG_C_LSB = 4;
    localparam int CFG_W = 6;
    localparam logic [5:0] CFG_RESET = 6'h00;
    localparam logic [1:0] SEL_A_TX = 2'h0;
    localparam logic [1:0] SEL_A_RX = 2'h1;
    localparam logic [1:0] SEL_A_LINK = 2'h2;
    localparam logic [1:0] SEL_B_RX = 2'h0;
    localparam logic [1:0] SEL_B_LINK = 2'h1;
    localparam logic [1:0] SEL_B_DUPLEX = 2'h2;
    localparam logic [1:0] SEL_C_LINK = 2'h0;
    localparam logic [1:0] SEL_C_DUPLEX = 2'h1;
    localparam logic [1:0] SEL_C_SPEED = 2'h2;

    // Serializer states.
    typedef enum logic [1:0] {ST_GAP, ST_SHIFT} qli_ser_state_t;

endpackage

//--- qli_frame_if.sv
// Carrier for one indicator frame word passed from the system domain to the link domain.
`timescale 1ns/10ps
interface qli_frame_if;
    logic [23:0] word;
    logic req_tgl;
    logic ack_tgl;
    modport src (output word, output req_tgl, input ack_tgl);
    modport snk (input word, input req_tgl, output ack_tgl);
endinterface

//--- qli_led_sel.sv
// Per-port selector that maps line conditions onto the three indicators.
`timescale 1ns/10ps
module qli_led_sel (
    input wire logic [5:0] status_in,
    input wire logic [5:0] cfg_in,
    output logic on_a_out,
    output logic on_b_out,
    output logic on_c_out
);

    // ------------------------------------------------------------------
    // Selection
    // ------------------------------------------------------------------
    // Code 0 of each field is the default meaning, so a reset config shows it.
    always_comb
    begin
        case (cfg_in[qli_pkg::CFG_A_LSB +: 2])
            qli_pkg::SEL_A_TX: on_a_out = status_in[qli_pkg::ST_TX]; // [RQ1]
            qli_pkg::SEL_A_RX: on_a_out = status_in[qli_pkg::ST_RX]; // [RQ2]
            qli_pkg::SEL_A_LINK: on_a_out = status_in[qli_pkg::ST_LINK]; // [RQ2]
            default: on_a_out = status_in[qli_pkg::ST_DUPLEX]; // [RQ2]
        endcase
        case (cfg_in[qli_pkg::CFG_B_LSB +: 2])
            qli_pkg::SEL_B_RX: on_b_out = status_in[qli_pkg::ST_RX]; // [RQ3]
            qli_pkg::SEL_B_LINK: on_b_out = status_in[qli_pkg::ST_LINK]; // [RQ4]
            qli_pkg::SEL_B_DUPLEX: on_b_out = status_in[qli_pkg::ST_DUPLEX]; // [RQ4]
            default: on_b_out = status_in[qli_pkg::ST_SPEED]; // [RQ4]
        endcase
        case (cfg_in[qli_pkg::CFG_C_LSB +: 2])
            qli_pkg::SEL_C_LINK: on_c_out = status_in[qli_pkg::ST_LINK]; // [RQ5]
            qli_pkg::SEL_C_DUPLEX: on_c_out = status_in[qli_pkg::ST_DUPLEX]; // [RQ6]
            qli_pkg::SEL_C_SPEED: on_c_out = status_in[qli_pkg::ST_SPEED]; // [RQ6]
            default: on_c_out = status_in[qli_pkg::ST_COL]; // [RQ6]
        endcase
    end

endmodule // qli_led_sel

//--- qli_serializer.sv
// Link-domain serializer that streams indicator frames with shift clock and valid strobe.
`timescale 1ns/10ps
module qli_serializer (
    input wire logic link_clk_in,
    input wire logic rst_n_in,
    qli_frame_if.snk frm,
    output logic shift_clk_out,
    output logic bitstream_out,
    output logic valid_out
);

    typedef struct packed {
        logic rst_meta;
        logic rst_ok;
        logic req_meta;
        logic req_sync;
        logic ack;
        qli_pkg::qli_ser_state_t state;
        logic [4:0] cnt;
        logic [23:0] held;
        logic [23:0] shift;
        logic sclk;
        logic data;
        logic valid;
    } qli_ser_t;

    qli_ser_t r_reg;
    qli_ser_t r_next;
    logic [23:0] src;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    // Data and valid change only as the shift clock falls, so the receiver
    // samples mid-bit on the rising edge.
    always_comb
    begin
        r_next = r_reg;
        src = (r_reg.req_sync != r_reg.ack) ? frm.word : r_reg.held;
        r_next.rst_meta = rst_n_in;
        r_next.rst_ok = r_reg.rst_meta;
        r_next.req_meta = frm.req_tgl;
        r_next.req_sync = r_reg.req_meta;
        if (!r_reg.rst_ok)
        begin
            r_next.ack = 1'b0;
            r_next.state = qli_pkg::ST_GAP;
            r_next.cnt = 5'h00;
            r_next.held = 24'h000000;
            r_next.shift = 24'h000000;
            r_next.sclk = 1'b0;
            r_next.data = 1'b0;
            r_next.valid = 1'b0;
        end
        else
        begin
            r_next.sclk = ~r_reg.sclk; // [RQ8]
            if (r_reg.sclk)
            begin
                case (r_reg.state)
                    qli_pkg::ST_GAP:
                    begin
                        r_next.valid = 1'b0; // [RQ11]
                        r_next.data = 1'b0;
                        r_next.cnt = r_reg.cnt + 5'h01;
                        if (r_reg.cnt == qli_pkg::GAP_LAST)
                        begin
                            // A fresh word is taken only once its toggle has synchronised.
                            r_next.held = src;
                            r_next.ack = r_reg.req_sync;
                            r_next.shift = src;
                            r_next.data = src[0]; // [RQ9]
                            r_next.valid = 1'b1; // [RQ7]
                            r_next.cnt = 5'h00;
                            r_next.state = qli_pkg::ST_SHIFT;
                        end
                    end
                    default:
                    begin
                        r_next.shift = {1'b0, r_reg.shift[23:1]}; // [RQ11]
                        r_next.data = r_reg.shift[1];
                        r_next.cnt = r_reg.cnt + 5'h01;
                        if (r_reg.cnt == qli_pkg::FRAME_LAST)
                        begin
                            r_next.valid = 1'b0; // [RQ7]
                            r_next.data = 1'b0;
                            r_next.cnt = 5'h00;
                            r_next.state = qli_pkg::ST_GAP;
                        end
                    end
                endcase
            end
        end
    end

    // State register.
    always_ff @(posedge link_clk_in)
    begin
        r_reg <= r_next;
    end

    assign frm.ack_tgl = r_reg.ack;
    assign shift_clk_out = r_reg.sclk;
    assign bitstream_out = r_reg.data;
    assign valid_out = r_reg.valid;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_sclk_toggles;
        @(posedge link_clk_in) disable iff (!r_reg.rst_ok)
        r_reg.rst_ok && $past(r_reg.rst_ok) |=> shift_clk_out != $past(shift_clk_out);
    endproperty
    a_sclk_toggles: assert property (p_sclk_toggles) else $error("shift clock stalled"); // [RQ8]

    property p_valid_in_shift;
        @(posedge link_clk_in) disable iff (!r_reg.rst_ok)
        valid_out |-> r_reg.state == qli_pkg::ST_SHIFT && bitstream_out == r_reg.shift[0];
    endproperty
    a_valid_in_shift: assert property (p_valid_in_shift) else $error("valid outside frame"); // [RQ7]

    property p_frame_end;
        @(posedge link_clk_in) disable iff (!r_reg.rst_ok)
        r_reg.state == qli_pkg::ST_SHIFT && r_reg.cnt == 5'h17 && shift_clk_out
            |=> !valid_out ##1 !valid_out [*8];
    endproperty
    a_frame_end: assert property (p_frame_end) else $error("frame length or gap wrong"); // [RQ9]

    property p_edge_align;
        @(posedge link_clk_in) disable iff (!r_reg.rst_ok)
        $changed(valid_out) |-> !shift_clk_out;
    endproperty
    a_edge_align: assert property (p_edge_align) else $error("valid moved on rising edge"); // [RQ11]

    c_frame_start: cover property (@(posedge link_clk_in) $rose(valid_out));
    c_new_word: cover property (@(posedge link_clk_in) $changed(r_reg.ack));

endmodule // qli_serializer

//--- qli_top.sv
// Quad-port indicator block: APB registers, open-drain indicator pins, serial indicator link.
//
// Design decisions made here: the APB register port and the register addresses.
`timescale 1ns/10ps
// Functional notes
// [RQ1] After reset the first indicator of each port is pulled low while its transmitter is active.
// [RQ2] The first indicator may instead show receive activity, link or duplex by configuration.
// [RQ3] After reset the second indicator of each port is low while its receiver is active.
// [RQ4] The second indicator may instead show link, duplex or speed by configuration.
// [RQ5] After reset the third indicator of each port is low while its link is up.
// [RQ6] The third indicator may instead show duplex, speed or collision by configuration.
// [RQ7] The serial valid output is high exactly while the serial data carries indicator bits.
// [RQ8] A dedicated 25 MHz shift clock accompanies the serial data.
// [RQ9] Each frame carries 24 indicator states, six for each of four ports.
// [RQ10] The register space holds numbers 0 to 6 and 16 to 20, each sixteen bits wide.
// [RQ11] One bit per shift clock in ascending port then indicator order, frames repeat with valid low between.
// [RQ12] Indicator meanings come from per-port fields written by software, defaults until written.
module qli_top (
    input wire logic CLK_SYS_IN,
    input wire logic RESET_N_IN,
    input wire logic PSEL_IN,
    input wire logic PENABLE_IN,
    input wire logic PWRITE_IN,
    input wire logic [7:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    output logic [31:0] PRDATA_OUT,
    output logic PREADY_OUT,
    output logic PSLVERR_OUT,
    input wire logic [3:0] TX_ACTIVE_IN,
    input wire logic [3:0] RX_ACTIVE_IN,
    input wire logic [3:0] LINK_UP_IN,
    input wire logic [3:0] FULL_DUPLEX_IN,
    input wire logic [3:0] SPEED_100_IN,
    input wire logic [3:0] COLLISION_IN,
    input wire logic [3:0] PORT_LED_A_IN,
    output logic [3:0] PORT_LED_A_OUT,
    output logic [3:0] PORT_LED_A_OE_OUT,
    input wire logic [3:0] PORT_LED_B_IN,
    output logic [3:0] PORT_LED_B_OUT,
    output logic [3:0] PORT_LED_B_OE_OUT,
    input wire logic [3:0] PORT_LED_C_IN,
    output logic [3:0] PORT_LED_C_OUT,
    output logic [3:0] PORT_LED_C_OE_OUT,
    input wire logic SERIAL_LINK_CLK_IN,
    output logic SERIAL_LED_SHIFT_CLOCK_OUT,
    output logic SERIAL_LED_BITSTREAM_OUT,
    output logic SERIAL_LED_VALID_OUT
);

    typedef struct packed {
        logic [6:0][15:0] scratch;
        logic [3:0][5:0] cfg;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [3:0] oe_a;
        logic [3:0] oe_b;
        logic [3:0] oe_c;
        logic drive_lvl;
        logic [11:0] pin_meta;
        logic [11:0] pin_sync;
        logic [23:0] word;
        logic req;
        logic ack_meta;
        logic ack_sync;
    } qli_top_state_t;

    qli_top_state_t r_reg;
    qli_top_state_t r_next;
    logic [23:0] status_word;
    logic [3:0] on_a;
    logic [3:0] on_b;
    logic [3:0] on_c;
    logic [5:0] idx;
    logic [31:0] rd;
    logic err;
    logic access;

    qli_frame_if frm ();

    // ------------------------------------------------------------------
    // Per-port status gathering and indicator selection
    // ------------------------------------------------------------------
    // Each port contributes six bits, transmit first, so port 0 leads the frame.
    genvar p;
    generate
        for (p = 0; p < qli_pkg::NUM_PORTS; p++)
        begin : g_port
            assign status_word[p * qli_pkg::BITS_PER_PORT +: qli_pkg::BITS_PER_PORT] =
                {COLLISION_IN[p], SPEED_100_IN[p], FULL_DUPLEX_IN[p],
                 LINK_UP_IN[p], RX_ACTIVE_IN[p], TX_ACTIVE_IN[p]}; // [RQ9]

            qli_led_sel u_sel (
                .status_in(status_word[p * qli_pkg::BITS_PER_PORT +: qli_pkg::BITS_PER_PORT]),
                .cfg_in(r_reg.cfg[p]),
                .on_a_out(on_a[p]),
                .on_b_out(on_b[p]),
                .on_c_out(on_c[p])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Next state: register decode, APB answer, pins and frame handoff
    // ------------------------------------------------------------------
    // The slave inserts one wait state: ready rises one cycle into the access
    // phase, and writes commit only on the edge that completes the transfer.
    always_comb
    begin
        r_next = r_reg;
        idx = PADDR_IN[7:2];
        rd = 32'h00000000;
        err = 1'b0;
        access = PSEL_IN && PENABLE_IN;
        if (PADDR_IN[1:0] != 2'h0)
        begin
            err = 1'b1;
        end
        else if (idx <= qli_pkg::REG_IDX_SCRATCH_HI)
        begin
            rd = {16'h0000, r_reg.scratch[idx[2:0]]}; // [RQ10]
        end
        else if (idx >= qli_pkg::REG_IDX_LEDCFG_LO && idx <= qli_pkg::REG_IDX_LEDCFG_HI)
        begin
            rd = {26'h0000000, r_reg.cfg[idx[1:0]]}; // [RQ10]
        end
        else if (idx == qli_pkg::REG_IDX_PINS)
        begin
            rd = {20'h00000, r_reg.pin_sync}; // [RQ10]
        end
        else
        begin
            err = 1'b1;
        end

        // Answer phase.
        r_next.pready = access && !r_reg.pready;
        r_next.pslverr = access && !r_reg.pready && err;
        r_next.prdata = (access && !r_reg.pready && !PWRITE_IN) ? rd : 32'h00000000;

        // Write commit; the pin register is read-only and ignores writes.
        if (access && r_reg.pready && PWRITE_IN && !err)
        begin
            if (idx <= qli_pkg::REG_IDX_SCRATCH_HI)
            begin
                r_next.scratch[idx[2:0]] = PWDATA_IN[15:0];
            end
            else if (idx >= qli_pkg::REG_IDX_LEDCFG_LO && idx <= qli_pkg::REG_IDX_LEDCFG_HI)
            begin
                r_next.cfg[idx[1:0]] = PWDATA_IN[5:0]; // [RQ12]
            end
        end

        // Open drain: the pin is pulled low by enabling a driver held at zero.
        r_next.oe_a = on_a; // [RQ1]
        r_next.oe_b = on_b; // [RQ3]
        r_next.oe_c = on_c; // [RQ5]
        r_next.drive_lvl = 1'b0;
        r_next.pin_meta = {PORT_LED_C_IN, PORT_LED_B_IN, PORT_LED_A_IN};
        r_next.pin_sync = r_reg.pin_meta;

        // A new word is posted only after the link side acknowledged the last,
        // so the word never changes while the other domain may capture it.
        r_next.ack_meta = frm.ack_tgl;
        r_next.ack_sync = r_reg.ack_meta;
        if (r_reg.req == r_reg.ack_sync)
        begin
            r_next.word = status_word; // [RQ11]
            r_next.req = ~r_reg.req;
        end

        if (!RESET_N_IN)
        begin
            r_next = '0;
            for (int i = 0; i < qli_pkg::NUM_PORTS; i++)
            begin
                r_next.cfg[i] = qli_pkg::CFG_RESET; // [RQ12]
            end
        end
    end

    // State register.
    always_ff @(posedge CLK_SYS_IN)
    begin
        r_reg <= r_next;
    end

    // ------------------------------------------------------------------
    // Outputs and link-side serializer
    // ------------------------------------------------------------------
    assign PRDATA_OUT = r_reg.prdata;
    assign PREADY_OUT = r_reg.pready;
    assign PSLVERR_OUT = r_reg.pslverr;
    assign PORT_LED_A_OUT = {4{r_reg.drive_lvl}};
    assign PORT_LED_B_OUT = {4{r_reg.drive_lvl}};
    assign PORT_LED_C_OUT = {4{r_reg.drive_lvl}};
    assign PORT_LED_A_OE_OUT = r_reg.oe_a;
    assign PORT_LED_B_OE_OUT = r_reg.oe_b;
    assign PORT_LED_C_OE_OUT = r_reg.oe_c;
    assign frm.word = r_reg.word;
    assign frm.req_tgl = r_reg.req;

    // The link clock must run at twice the shift rate for a 25 MHz shift clock.
    qli_serializer u_ser (
        .link_clk_in(SERIAL_LINK_CLK_IN),
        .rst_n_in(RESET_N_IN),
        .frm(frm.snk),
        .shift_clk_out(SERIAL_LED_SHIFT_CLOCK_OUT),
        .bitstream_out(SERIAL_LED_BITSTREAM_OUT),
        .valid_out(SERIAL_LED_VALID_OUT)
    );

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb_sys @(posedge CLK_SYS_IN);
    endclocking
    default disable iff (!RESET_N_IN);

    generate
        for (p = 0; p < qli_pkg::NUM_PORTS; p++)
        begin : g_chk
            property p_led_a_default;
                r_reg.cfg[p][1:0] == 2'h0 |=> PORT_LED_A_OE_OUT[p] == $past(TX_ACTIVE_IN[p]);
            endproperty
            a_led_a_default: assert property (p_led_a_default) else $error("led a not tx"); // [RQ1]

            property p_led_a_link;
                r_reg.cfg[p][1:0] == 2'h2 |=> PORT_LED_A_OE_OUT[p] == $past(LINK_UP_IN[p]);
            endproperty
            a_led_a_link: assert property (p_led_a_link) else $error("led a not link"); // [RQ2]

            property p_led_b_default;
                r_reg.cfg[p][3:2] == 2'h0 |=> PORT_LED_B_OE_OUT[p] == $past(RX_ACTIVE_IN[p]);
            endproperty
            a_led_b_default: assert property (p_led_b_default) else $error("led b not rx"); // [RQ3]

            property p_led_b_speed;
                r_reg.cfg[p][3:2] == 2'h3 |=> PORT_LED_B_OE_OUT[p] == $past(SPEED_100_IN[p]);
            endproperty
            a_led_b_speed: assert property (p_led_b_speed) else $error("led b not speed"); // [RQ4]

            property p_led_c_default;
                r_reg.cfg[p][5:4] == 2'h0 |=> PORT_LED_C_OE_OUT[p] == $past(LINK_UP_IN[p]);
            endproperty
            a_led_c_default: assert property (p_led_c_default) else $error("led c not link"); // [RQ5]

            property p_led_c_col;
                r_reg.cfg[p][5:4] == 2'h3 |=> PORT_LED_C_OE_OUT[p] == $past(COLLISION_IN[p]);
            endproperty
            a_led_c_col: assert property (p_led_c_col) else $error("led c not collision"); // [RQ6]
        end
    endgenerate

    property p_cfg_write;
        access && PREADY_OUT && PWRITE_IN && PADDR_IN == 8'h40
            |=> r_reg.cfg[0] == $past(PWDATA_IN[5:0]);
    endproperty
    a_cfg_write: assert property (p_cfg_write) else $error("config write lost"); // [RQ12]

    property p_cfg_hold;
        !(access && PWRITE_IN) |=> $stable(r_reg.cfg);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold) else $error("config changed without write"); // [RQ12]

    property p_unmapped;
        access && !PREADY_OUT && PADDR_IN == 8'h1C |=> PREADY_OUT && PSLVERR_OUT;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("hole not refused"); // [RQ10]

    property p_pins_read;
        access && !PREADY_OUT && !PWRITE_IN && PADDR_IN == 8'h50
            |=> PREADY_OUT && !PSLVERR_OUT && PRDATA_OUT[31:12] == 20'h00000;
    endproperty
    a_pins_read: assert property (p_pins_read) else $error("pin register read bad"); // [RQ10]

    property p_word_stable;
        r_reg.req != r_reg.ack_sync |=> $stable(r_reg.word);
    endproperty
    a_word_stable: assert property (p_word_stable) else $error("word moved in flight"); // [RQ11]

    c_cfg_write: cover property (access && PREADY_OUT && PWRITE_IN && PADDR_IN == 8'h44);
    c_scratch_read: cover property (access && PREADY_OUT && !PWRITE_IN && PADDR_IN == 8'h18);
    c_word_post: cover property (r_reg.req != $past(r_reg.req));

endmodule // qli_top

//--- qli_led_rx.sv
// Model of the external shift register that takes the serial indicator frames.
`timescale 1ns/10ps
module qli_led_rx (
    input wire logic sclk_in,
    input wire logic data_in,
    input wire logic valid_in,
    output logic [23:0] word_out,
    output logic [5:0] bits_out,
    output logic [5:0] gap_out,
    output int frames_out
);
    logic [23:0] shift_reg = 24'h0;
    logic [5:0] cnt_reg = 6'h0;
    logic [5:0] gap_reg = 6'h0;
    initial frames_out = 0;
    // Data is taken on the rising shift clock only while valid is high; a frame ends
    // when valid drops, so a stuck valid shows up as a missing frame.
    always @(posedge sclk_in)
    begin
        if (valid_in === 1'b1)
        begin
            shift_reg[cnt_reg[4:0]] <= data_in;
            cnt_reg <= cnt_reg + 6'h01;
            gap_reg <= 6'h00;
            if (cnt_reg == 6'h00)
                gap_out <= gap_reg;
        end
        else
        begin
            gap_reg <= gap_reg + 6'h01;
            if (cnt_reg != 6'h00)
            begin
                word_out <= shift_reg;
                bits_out <= cnt_reg;
                frames_out <= frames_out + 1;
                cnt_reg <= 6'h00;
            end
        end
    end
endmodule // qli_led_rx

//--- tb.sv
// Self-checking bench for the quad-port indicator block.
`timescale 1ns/10ps
module tb;
    logic clk = 1'b0;
    logic lclk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, sclk, sdat, sval;
    logic [3:0] cond [6] = '{default: 4'h0};
    logic [3:0] oe_a, oe_b, oe_c;
    logic [11:0] lvl;
    logic [23:0] rx_word;
    logic [5:0] rx_bits, rx_gap;
    int rx_frames;
    int miscompares = 0;
    int cmp_count = 0;
    int seed = 32'h15d1;
    // Clocks of 20 ns and 15 ns; their rising edges never coincide.
    always #10 clk = ~clk;
    always #7.5 lclk = ~lclk;
    // Pads are pulled up, so a pin reads low only while its driver is enabled.
    qli_top u_qli_top (.CLK_SYS_IN(clk), .RESET_N_IN(rst_n), .PSEL_IN(psel),
        .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
        .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
        .TX_ACTIVE_IN(cond[0]), .RX_ACTIVE_IN(cond[1]), .LINK_UP_IN(cond[2]),
        .FULL_DUPLEX_IN(cond[3]), .SPEED_100_IN(cond[4]), .COLLISION_IN(cond[5]),
        .PORT_LED_A_IN(~oe_a), .PORT_LED_A_OUT(lvl[3:0]), .PORT_LED_A_OE_OUT(oe_a),
        .PORT_LED_B_IN(~oe_b), .PORT_LED_B_OUT(lvl[7:4]), .PORT_LED_B_OE_OUT(oe_b),
        .PORT_LED_C_IN(~oe_c), .PORT_LED_C_OUT(lvl[11:8]), .PORT_LED_C_OE_OUT(oe_c),
        .SERIAL_LINK_CLK_IN(lclk), .SERIAL_LED_SHIFT_CLOCK_OUT(sclk),
        .SERIAL_LED_BITSTREAM_OUT(sdat), .SERIAL_LED_VALID_OUT(sval));
    qli_led_rx u_qli_led_rx (.sclk_in(sclk), .data_in(sdat), .valid_in(sval),
        .word_out(rx_word), .bits_out(rx_bits), .gap_out(rx_gap), .frames_out(rx_frames));
    // ----------------------------------------------------------------
    // Checking, expectation and bus tasks
    // ----------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Register map as software sees it; config is left at selector 3 before this is used.
    function automatic logic [32:0] exp_reg(input int i, input logic [31:0] w);
        if (i <= 6)
            return {17'h0, w[15:0]};
        if (i >= 16 && i <= 19)
            return 33'h3F;
        if (i == 20)
            return {21'h0, ~cond[5], ~cond[4], ~cond[3]};
        return {1'b1, 32'h0};
    endfunction
    function automatic logic [23:0] exp_word();
        logic [23:0] w;
        for (int b = 0; b < 24; b++)
            w[b] = cond[b % 6][b / 6];
        return w;
    endfunction
    task automatic set_cond();
        for (int k = 0; k < 6; k++)
            cond[k] <= 4'($random(seed));
    endtask
    // Called right after a rising edge; holds the request until pready is sampled.
    task automatic apb(input logic wr, input int i, input logic [31:0] wd,
        output logic [32:0] res);
        int n;
        psel <= 1'b1;
        pwr <= wr;
        paddr <= {6'(i), 2'b00};
        pwdata <= wd;
        @(posedge clk);
        pen <= 1'b1;
        for (n = 0; n < 20 && pready !== 1'b1; n++)
            @(posedge clk);
        if (n == 20)
            chk("apb ready timeout", 32'h0, 32'h1);
        if (n == 20)
            final_report();
        res = {pslverr, prdata};
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask
    initial
    begin
        logic [32:0] r;
        logic [31:0] w;
        int f;
        int n;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        // Step 0 checks the defaults, steps 1 to 4 program every selector code.
        for (int s = 0; s < 5; s++)
        begin
            for (int p = 0; p < 4 && s > 0; p++)
                apb(1'b1, 16 + p, {26'h0, {3{2'(s - 1)}}}, r);
            repeat (4)
            begin
                set_cond();
                repeat (2) @(posedge clk);
                chk("led a", 32'(oe_a), 32'(cond[s > 0 ? s - 1 : 0]));
                chk("led b", 32'(oe_b), 32'(cond[(s > 0 ? s - 1 : 0) + 1]));
                chk("led c", 32'(oe_c), 32'(cond[(s > 0 ? s - 1 : 0) + 2]));
                chk("drive level", 32'(lvl), 32'h0);
            end
        end
        $display("led test done");
        // Every index from 0 to 21; config writes are skipped to keep selector 3.
        for (int i = 0; i < 22; i++)
        begin
            w = $random(seed);
            if (i < 16 || i > 19)
                apb(1'b1, i, w, r);
            if (i < 16 || i > 19)
                chk("write error", 32'(r[32]), 32'(exp_reg(i, w) >> 32));
            apb(1'b0, i, 32'h0, r);
            chk("read value", r[31:0], 32'(exp_reg(i, w)));
            chk("read error", 32'(r[32]), 32'(exp_reg(i, w) >> 32));
        end
        $display("register test done");
        repeat (3)
        begin
            set_cond();
            f = rx_frames;
            for (n = 0; n < 800 && rx_frames < f + 3; n++)
                @(posedge clk);
            chk("frame wait", 32'(n < 800), 32'h1);
            if (n == 800)
                final_report();
            chk("frame word", 32'(rx_word), 32'(exp_word()));
            chk("frame bits", 32'(rx_bits), 32'(qli_pkg::FRAME_BITS));
            chk("frame gap", 32'(rx_gap), 32'(qli_pkg::GAP_BITS));
        end
        $display("serial test done");
        final_report();
    end
endmodule // tb
